/* File: src/glp_pkg.sv */
// Constants and types for the general-purpose pin latch port
package glp_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NPINS  = 3;
   // Pin configuration register offsets, second to fourth pin
   localparam logic [15:0] OFS_PIN_TWO   = 16'h0012;
   localparam logic [15:0] OFS_PIN_THREE = 16'h0013;
   localparam logic [15:0] OFS_PIN_FOUR  = 16'h0014;
   // Interrupt status, enable and clear registers
   localparam logic [15:0] OFS_IRQ_STATUS = 16'h0020;
   localparam logic [15:0] OFS_IRQ_ENABLE = 16'h0021;
   localparam logic [15:0] OFS_IRQ_CLEAR  = 16'h0022;
   // Field positions inside a pin register
   localparam int BIT_IN    = 0;
   localparam int BIT_OUT   = 1;
   localparam int BIT_OE    = 2;
   localparam int BIT_PP    = 3;
   localparam int BIT_POL   = 4;
   localparam int BIT_MASK  = 5;
   localparam int BIT_CLR   = 6;
   localparam int BIT_LATCH = 7;
   // Reset values of the writable fields
   localparam logic RST_OUT  = 1'b0;
   localparam logic RST_OE   = 1'b0;
   localparam logic RST_PP   = 1'b0;
   localparam logic RST_POL  = 1'b0;
   localparam logic RST_MASK = 1'b1;
   localparam logic RST_CLR  = 1'b1;
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;
   localparam int SYNC_STAGES = 2;
endpackage

/* File: src/glp_cfg_if.sv */
// Per-pin configuration and status bundle
`timescale 1ns/1ps
interface glp_cfg_if;
   logic out_val;
   logic out_en;
   logic push_pull;
   logic polarity;
   logic mask;
   logic clear;
   logic in_sync;
   logic latch;
   modport ctrl (output out_val, out_en, push_pull, polarity, mask, clear,
                 input in_sync, latch);
   modport pin  (input out_val, out_en, push_pull, polarity, mask, clear,
                 output in_sync, latch);
endinterface

/* File: src/glp_pin.sv */
// One pin: synchroniser, latch and driver
`timescale 1ns/1ps
module glp_pin
   import glp_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // Pad
   input  wire logic pad_in,
   output logic      pad_out,
   output logic      pad_oe,
   // Configuration
   glp_cfg_if.pin    cfg
);
   logic [SYNC_STAGES-1:0] sync;
   logic                   latch;
   logic                   next_latch;
   logic                   next_oe;
   logic                   hit;

   // Only the last stage is read
   assign cfg.in_sync = sync[SYNC_STAGES-1];
   assign cfg.latch   = latch;
   assign hit         = (cfg.in_sync == cfg.polarity);
   // Clear holds the latch low even against a matching level
   assign next_latch  = cfg.clear ? 1'b0 : (latch | hit);
   // Open drain only ever pulls low, so a high value releases the pin
   assign next_oe     = cfg.out_en & (cfg.push_pull | ~cfg.out_val);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync <= '0;
      end else if (clk_en) begin
         sync <= {sync[SYNC_STAGES-2:0], pad_in};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         latch <= 1'b0;
      end else if (clk_en) begin
         latch <= next_latch;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
      end else if (clk_en) begin
         pad_out <= cfg.out_val;
         pad_oe  <= next_oe;
      end
   end

   chk_latch_held : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && $past(clk_en) && $past(cfg.clear)) |-> !latch)
      else $error("latch set while held clear");
   chk_latch_sticky : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && latch && !cfg.clear) |=> (latch || $past(cfg.clear)))
      else $error("latch dropped without clear");
   chk_latch_sets : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !cfg.clear && cfg.in_sync == cfg.polarity) |=> latch)
      else $error("matching level did not set latch");
   chk_od_release : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !cfg.push_pull && cfg.out_val) |=> !pad_oe)
      else $error("open drain drove high");
   chk_oe_off : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !cfg.out_en) |=> !pad_oe)
      else $error("pin driven while disabled");
   chk_pp_drive : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && cfg.out_en && cfg.push_pull) |=> (pad_oe && pad_out == $past(cfg.out_val)))
      else $error("push-pull value not driven");
endmodule

/* File: src/glp_top.sv */
// Three general-purpose pins with level latches and interrupt
`timescale 1ns/1ps
// Overview of operation
// - Third pin register at 0013h, fixed layout
// - Fourth pin register at 0014h, same layout
// - Output bit sets driven level, reset 0
// - Output enable 0 tri-states, 1 drives
// - Drive bit: 0 open-drain, 1 push-pull
// - Polarity picks level that sets latch
// - Mask bit 1 blocks latch-level interrupt, not the enabled status path, latch still sets, reset 1
// - Mask bit 0 lets latch interrupt
// - Clear bit 1 holds latch at 0
// - Clear bit 0 lets latch set
// - Each pin has its own drive choice
// - Masked latch stays readable for polling
// - Interrupt is OR of unmasked latches and enabled status bits
module glp_top
   import glp_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      clk_en,
   // Register port
   input  wire logic [glp_pkg::ADDR_W-1:0] internal_address_value,
   input  wire logic [glp_pkg::DATA_W-1:0] wr_data,
   input  wire logic                      wr_strobe,
   input  wire logic                      rd_strobe,
   output logic      [glp_pkg::DATA_W-1:0] register_data_byte,
   // Pins
   input  wire logic [glp_pkg::NPINS-1:0]  pin_in,
   output logic      [glp_pkg::NPINS-1:0]  pin_out,
   output logic      [glp_pkg::NPINS-1:0]  pin_oe,
   // Interrupt
   output logic                           irq
);
   import glp_pkg::*;

   logic [NPINS-1:0] out_val;
   logic [NPINS-1:0] out_en;
   logic [NPINS-1:0] push_pull;
   logic [NPINS-1:0] polarity;
   logic [NPINS-1:0] mask;
   logic [NPINS-1:0] clear;
   logic [NPINS-1:0] in_sync;
   logic [NPINS-1:0] latch;
   logic [NPINS-1:0] irq_status;
   logic [NPINS-1:0] irq_enable;
   logic [NPINS-1:0] latch_q;
   logic [NPINS-1:0] latch_rise;
   logic [NPINS-1:0] sel_pin;
   logic [NPINS-1:0] wr_pin;
   logic             wr_enable;
   logic             wr_clear;
   logic [NPINS-1:0] clr_bits;
   logic [NPINS-1:0] next_irq_status;
   logic             next_irq;
   logic [7:0]       pin_byte [NPINS];
   logic [7:0]       next_rdata;

   glp_cfg_if cfg_bus [NPINS] ();

   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         assign cfg_bus[g].out_val   = out_val[g];
         assign cfg_bus[g].out_en    = out_en[g];
         assign cfg_bus[g].push_pull = push_pull[g];
         assign cfg_bus[g].polarity  = polarity[g];
         assign cfg_bus[g].mask      = mask[g];
         assign cfg_bus[g].clear     = clear[g];
         assign in_sync[g]           = cfg_bus[g].in_sync;
         assign latch[g]             = cfg_bus[g].latch;

         glp_pin u_pin (
            .clk     (clk),
            .sys_rst (sys_rst),
            .clk_en  (clk_en),
            .pad_in  (pin_in[g]),
            .pad_out (pin_out[g]),
            .pad_oe  (pin_oe[g]),
            .cfg     (cfg_bus[g])
         );

         // Readback keeps the latch visible even when masked
         assign pin_byte[g] = {latch[g], clear[g], mask[g], polarity[g],
                               push_pull[g], out_en[g], out_val[g], in_sync[g]};
      end
   endgenerate

   // Address decode
   assign sel_pin[0] = (internal_address_value == OFS_PIN_TWO);
   assign sel_pin[1] = (internal_address_value == OFS_PIN_THREE);
   assign sel_pin[2] = (internal_address_value == OFS_PIN_FOUR);
   assign wr_pin     = sel_pin & {NPINS{wr_strobe}};
   assign wr_enable  = wr_strobe && (internal_address_value == OFS_IRQ_ENABLE);
   assign wr_clear   = wr_strobe && (internal_address_value == OFS_IRQ_CLEAR);
   assign clr_bits   = wr_clear ? wr_data[NPINS-1:0] : '0;

   // Read mux; unmapped addresses return zero
   assign next_rdata =
      sel_pin[0] ? pin_byte[0] :
      sel_pin[1] ? pin_byte[1] :
      sel_pin[2] ? pin_byte[2] :
      (internal_address_value == OFS_IRQ_STATUS) ? {5'h00, irq_status} :
      (internal_address_value == OFS_IRQ_ENABLE) ? {5'h00, irq_enable} :
      READ_UNMAPPED;

   // New latch events are sticky; a set in the clearing cycle wins
   assign latch_rise      = latch & ~latch_q;
   assign next_irq_status = (irq_status & ~clr_bits) | latch_rise;

   // Unmasked latches plus enabled status events drive the line
   assign next_irq = (|(latch & ~mask)) | (|(irq_status & irq_enable));

   // Writable pin fields
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_val   <= {NPINS{RST_OUT}};
         out_en    <= {NPINS{RST_OE}};
         push_pull <= {NPINS{RST_PP}};
         polarity  <= {NPINS{RST_POL}};
         mask      <= {NPINS{RST_MASK}};
         clear     <= {NPINS{RST_CLR}};
      end else if (clk_en) begin
         for (int i = 0; i < NPINS; i++) begin
            if (wr_pin[i]) begin
               out_val[i]   <= wr_data[BIT_OUT];
               out_en[i]    <= wr_data[BIT_OE];
               push_pull[i] <= wr_data[BIT_PP];
               polarity[i]  <= wr_data[BIT_POL];
               mask[i]      <= wr_data[BIT_MASK];
               clear[i]     <= wr_data[BIT_CLR];
            end
         end
      end
   end

   // Interrupt status, enable and edge history
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status <= '0;
         irq_enable <= RST_IRQ_ENABLE[NPINS-1:0];
         latch_q    <= '0;
      end else if (clk_en) begin
         irq_status <= next_irq_status;
         latch_q    <= latch;
         if (wr_enable) begin
            irq_enable <= wr_data[NPINS-1:0];
         end
      end
   end

   // Registered outputs; read data only in the cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         register_data_byte <= '0;
         irq                <= 1'b0;
      end else if (clk_en) begin
         register_data_byte <= rd_strobe ? next_rdata : '0;
         irq                <= next_irq;
      end
   end

   chk_masked_quiet : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && (&mask) && ((irq_status & irq_enable) == '0)) |=> !irq)
      else $error("masked latches raised interrupt");
   chk_unmasked_irq : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && |(latch & ~mask)) |=> irq)
      else $error("unmasked latch gave no interrupt");
   chk_read_latch : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && rd_strobe && sel_pin[1])
         |=> register_data_byte[BIT_LATCH] == $past(latch[1]))
      else $error("latch not readable");
   chk_write_third : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && wr_strobe && internal_address_value == OFS_PIN_THREE)
         |=> mask[1] == $past(wr_data[BIT_MASK]) && clear[1] == $past(wr_data[BIT_CLR]))
      else $error("third pin register not written");
   chk_write_fourth : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && wr_strobe && internal_address_value == OFS_PIN_FOUR)
         |=> polarity[2] == $past(wr_data[BIT_POL]) && out_en[2] == $past(wr_data[BIT_OE]))
      else $error("fourth pin register not written");
   chk_sync_delay : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && $past(clk_en) && $past(clk_en, 2) && !$past(sys_rst) && !$past(sys_rst, 2))
         |-> in_sync[0] == $past(pin_in[0], 2))
      else $error("input not two flops late");
endmodule

/* File: test/glp_pad_model.sv */
// Pad environment model: external driver and pull-up per pin
`timescale 1ns/1ps
module glp_pad_model (
   // From device
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   // External driver
   input  wire logic [2:0] ext_en,
   input  wire logic [2:0] ext_val,
   // Level seen by device
   output logic      [2:0] pin_in
);
   // Pull-up when nobody drives, so open drain reads high
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the pin latch port
`timescale 1ns/1ps
module tb_top;
   import glp_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr_strobe = 1'b0;
   logic        rd_strobe = 1'b0;
   logic        clk_en = 1'b1;
   logic [7:0]  rdata;
   logic [2:0]  pin_in;
   logic [2:0]  pin_out;
   logic [2:0]  pin_oe;
   logic [2:0]  ext_en = 3'h0;
   logic [2:0]  ext_val = 3'h0;
   logic        irq;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cycles = 0;

   always #12.5 clk = ~clk;

   glp_top glp_top_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .internal_address_value(addr), .wr_data(wdata), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .register_data_byte(rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   glp_pad_model glp_pad_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1;
      chk(what, rdata, exp);
   endtask

   task automatic t_reset;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         rd_chk(16'h0012 + 16'(i), 8'h61, "pin reset");
      end
      chk("oe reset", {5'h0, pin_oe}, 8'h00);
      chk("irq reset", {7'h0, irq}, 8'h00);
      wr(16'h0015, 8'hFF);
      rd_chk(16'h0015, 8'h00, "unmapped");
      @(posedge clk);
      #1;
      chk("read idle", rdata, 8'h00);
      rd_chk(16'h0021, 8'h00, "enable reset");
      $display("done reset");
   endtask

   task automatic t_drive;
      logic [7:0] cfg [3] = '{8'h6E, 8'h64, 8'h66};
      logic [1:0] oe_out [3] = '{2'b11, 2'b10, 2'b00};
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 3; k++) begin
            wr(16'h0012 + 16'(i), cfg[k]);
            repeat (3) @(posedge clk);
            #1;
            chk("pin oe", {5'h0, pin_oe}, 8'(oe_out[k][1]) << i);
            chk("pin out", {5'h0, pin_out & pin_oe}, 8'(oe_out[k][0]) << i);
            rd_chk(16'h0012 + 16'(i), cfg[k] | 8'(cfg[k][1]), "readback");
         end
         wr(16'h0012 + 16'(i), 8'h60);
      end
      $display("done drive");
   endtask

   // Idle level is the opposite of the polarity, a short pulse sets the latch
   task automatic t_latch(input int i, input logic pol);
      logic [15:0] a;
      a = 16'h0012 + 16'(i);
      ext_en[i] <= 1'b1;
      ext_val[i] <= ~pol;
      wr(a, {3'b000, pol, 4'h0});
      repeat (4) @(posedge clk);
      rd_chk(a, {3'b000, pol, 3'b000, ~pol}, "latch idle");
      chk("irq idle", {7'h0, irq}, 8'h00);
      ext_val[i] <= pol;
      repeat (2) @(posedge clk);
      ext_val[i] <= ~pol;
      repeat (5) @(posedge clk);
      rd_chk(a, {3'b100, pol, 3'b000, ~pol}, "latch set");
      chk("irq set", {7'h0, irq}, 8'h01);
      wr(a, {3'b001, pol, 4'h0});
      repeat (3) @(posedge clk);
      chk("irq masked", {7'h0, irq}, 8'h00);
      rd_chk(a, {3'b101, pol, 3'b000, ~pol}, "latch poll");
      ext_val[i] <= pol;
      wr(a, {3'b011, pol, 4'h0});
      repeat (5) @(posedge clk);
      rd_chk(a, {3'b011, pol, 3'b000, pol}, "latch held");
      ext_en[i] <= 1'b0;
      wr(a, 8'h60);
      $display("done latch");
   endtask

   // A write while the enable is low must leave every field untouched
   task automatic t_freeze;
      clk_en <= 1'b0;
      wr(16'h0012, 8'h6E);
      repeat (2) @(posedge clk);
      chk("frozen oe", {5'h0, pin_oe}, 8'h00);
      clk_en <= 1'b1;
      rd_chk(16'h0012, 8'h61, "frozen write");
      $display("done freeze");
   endtask

   task automatic t_irq_regs;
      rd_chk(16'h0020, 8'h07, "status");
      wr(16'h0021, 8'h02);
      repeat (3) @(posedge clk);
      chk("irq enabled", {7'h0, irq}, 8'h01);
      wr(16'h0022, 8'h07);
      repeat (3) @(posedge clk);
      chk("irq cleared", {7'h0, irq}, 8'h00);
      rd_chk(16'h0020, 8'h00, "status cleared");
      rd_chk(16'h0021, 8'h02, "enable");
      $display("done irq regs");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_drive();
      t_latch(2, 1'b1);
      t_latch(1, 1'b0);
      t_latch(0, 1'b1);
      t_freeze();
      t_irq_regs();
      tally_and_finish();
   end
endmodule
